/* pkg/rcf_pkg.sv */
// Shared constants and state types for the reset-cause flag block
package rcf_pkg;

	// Register offsets on the plain register port
	localparam logic [3:0] RCF_OFF_FLAGS = 4'h0;
	localparam logic [3:0] RCF_OFF_IRQ_STAT = 4'h1;
	localparam logic [3:0] RCF_OFF_IRQ_MASK = 4'h2;

	// Bit positions inside the flag register
	localparam int RCF_BIT_WINDOW = 5;
	localparam int RCF_BIT_TIMEOUT = 4;
	localparam int RCF_BIT_PIN = 3;
	localparam int RCF_BIT_INSTR = 2;
	localparam int RCF_BIT_POWER_ON = 1;
	localparam int RCF_BIT_LO = 1;
	localparam int RCF_BIT_HI = 5;

	// Values after power-on or brown-out reset
	localparam logic [7:0] RCF_FLAGS_RST = 8'h3c;
	localparam logic [7:0] RCF_STAT_RST = 8'h00;
	localparam logic [7:0] RCF_MASK_RST = 8'h00;

	// Implemented bits; all others read as zero
	localparam logic [7:0] RCF_FLAGS_MASK = 8'h3e;
	localparam logic [7:0] RCF_CAUSE_MASK = 8'h3c;

	typedef struct packed {
		logic [7:0] rdata;
		logic [7:0] stat;
		logic [7:0] mask;
		logic viol_req;
		logic post_rst;
	} rcf_top_state_t;

	typedef struct packed {
		logic flag;
	} rcf_cell_state_t;

endpackage

/* src/rcf_flag_cell.sv */
// One active-low reset-cause flag bit with hardware clear and firmware write
module rcf_flag_cell
	import rcf_pkg::*;
#(
	parameter logic RST_VAL = 1'b1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic hw_clr,
	input wire logic wr_en,
	input wire logic wr_val,
	output logic flag
);

	rcf_cell_state_t st_q;
	rcf_cell_state_t st_d;

	// Hardware event beats a firmware write in the same cycle, so no cause is lost
	always_comb begin
		st_d = st_q;
		if (hw_clr) begin
			st_d.flag = 1'b0;
		end else if (wr_en) begin
			st_d.flag = wr_val;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_q <= '{flag: RST_VAL};
		end else begin
			st_q <= st_d;
		end
	end

	assign flag = st_q.flag;

endmodule

/* src/rcf_top.sv */
// Reset-cause flag register with register port and cause interrupt
module rcf_top
	import rcf_pkg::*;
#(
	parameter int ADDR_W = 4,
	parameter int DATA_W = 8
) (
	input wire logic SYS_CLK,
	input wire logic SYS_RST,
	input wire logic [ADDR_W-1:0] REG_ADDR,
	input wire logic [DATA_W-1:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [DATA_W-1:0] REG_RDATA,
	input wire logic WDT_WINDOW_RST,
	input wire logic WDT_TIMEOUT_RST,
	input wire logic PIN_RESET,
	input wire logic RESET_INSTR,
	input wire logic WDT_CLEAR_INSTR,
	input wire logic WDT_WINDOW_OPEN,
	output logic WINDOW_VIOL_REQ,
	output logic [DATA_W-1:0] CAUSE_FLAGS,
	output logic IRQ
);

	// Address match, shared by the write and read decoders
	function automatic logic addr_hit(
		input logic [ADDR_W-1:0] addr,
		input logic [3:0] off
	);
		addr_hit = (addr == ADDR_W'(off));
	endfunction

	rcf_top_state_t st_q;
	rcf_top_state_t st_d;

	logic instr_viol;
	logic [7:0] hw_ev;
	logic [7:0] flags;
	logic wr_flags;
	logic wr_stat;
	logic wr_mask;

	// A clear instruction outside the open window is a violation
	assign instr_viol = WDT_CLEAR_INSTR & ~WDT_WINDOW_OPEN;

	// Each cause drives only its own bit; bit 1 has no runtime cause
	always_comb begin
		hw_ev = 8'h00;
		hw_ev[RCF_BIT_WINDOW] = WDT_WINDOW_RST | instr_viol;
		hw_ev[RCF_BIT_TIMEOUT] = WDT_TIMEOUT_RST;
		hw_ev[RCF_BIT_PIN] = PIN_RESET;
		hw_ev[RCF_BIT_INSTR] = RESET_INSTR;
	end

	assign wr_flags = REG_WR & addr_hit(REG_ADDR, RCF_OFF_FLAGS);
	assign wr_stat = REG_WR & addr_hit(REG_ADDR, RCF_OFF_IRQ_STAT);
	assign wr_mask = REG_WR & addr_hit(REG_ADDR, RCF_OFF_IRQ_MASK);

	// Flags beyond bits 5..1 belong to other logic and read as zero here
	assign flags[7:6] = 2'b00;
	assign flags[0] = 1'b0;

	// Reset value per bit comes from the package; hardware may only clear
	for (genvar i = RCF_BIT_LO; i <= RCF_BIT_HI; i++) begin : g_flag
		rcf_flag_cell #(
			.RST_VAL(RCF_FLAGS_RST[i])
		) u_cell (
			.clk(SYS_CLK),
			.rst(SYS_RST),
			.hw_clr(hw_ev[i]),
			.wr_en(wr_flags),
			.wr_val(REG_WDATA[i]),
			.flag(flags[i])
		);
	end

	always_comb begin
		st_d = st_q;
		st_d.post_rst = 1'b1;

		// Only a real violation requests a reset; firmware writes never do
		st_d.viol_req = instr_viol;

		// Sticky cause bits: a new event wins over a write-one clear
		if (wr_stat) begin
			st_d.stat = st_q.stat & ~(REG_WDATA[7:0] & RCF_CAUSE_MASK);
		end
		st_d.stat = st_d.stat | (hw_ev & RCF_CAUSE_MASK);

		if (wr_mask) begin
			st_d.mask = REG_WDATA[7:0] & RCF_CAUSE_MASK;
		end

		// Read data stand only in the cycle after the strobe
		st_d.rdata = 8'h00;
		if (REG_RD) begin
			if (addr_hit(REG_ADDR, RCF_OFF_FLAGS)) begin
				st_d.rdata = flags & RCF_FLAGS_MASK;
			end else if (addr_hit(REG_ADDR, RCF_OFF_IRQ_STAT)) begin
				st_d.rdata = st_q.stat;
			end else if (addr_hit(REG_ADDR, RCF_OFF_IRQ_MASK)) begin
				st_d.rdata = st_q.mask;
			end else begin
				st_d.rdata = 8'h00;
			end
		end
	end

	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			st_q <= '{
				rdata: 8'h00,
				stat: RCF_STAT_RST,
				mask: RCF_MASK_RST,
				viol_req: 1'b0,
				post_rst: 1'b0
			};
		end else begin
			st_q <= st_d;
		end
	end

	assign REG_RDATA = DATA_W'(st_q.rdata);
	assign CAUSE_FLAGS = DATA_W'(flags);
	assign WINDOW_VIOL_REQ = st_q.viol_req;
	assign IRQ = |(st_q.stat & st_q.mask);

	default clocking cb @(posedge SYS_CLK);
	endclocking

	default disable iff (SYS_RST);

	// First cycle after power-on reset shows the documented reset pattern
	a_reset_pattern: assert property (
		!st_q.post_rst |-> (flags == RCF_FLAGS_RST)
	) else $error("flags not at power-on values after reset");

	// Without a write, next flags are the old flags with event bits cleared
	a_cause_value: assert property (
		!wr_flags |=> (flags == ($past(flags) & ~($past(hw_ev) & RCF_FLAGS_MASK)))
	) else $error("flags do not follow the reset causes");

	a_window_clear: assert property (
		WDT_WINDOW_RST |=> !flags[RCF_BIT_WINDOW]
	) else $error("window flag not cleared by window reset");

	a_instr_window: assert property (
		(WDT_CLEAR_INSTR && !WDT_WINDOW_OPEN)
		|=> (!flags[RCF_BIT_WINDOW] && WINDOW_VIOL_REQ) ##1 !WINDOW_VIOL_REQ
			or (!flags[RCF_BIT_WINDOW] && WINDOW_VIOL_REQ ##1 WINDOW_VIOL_REQ)
	) else $error("closed-window clear not treated as violation");

	a_open_window_ok: assert property (
		(WDT_CLEAR_INSTR && WDT_WINDOW_OPEN) |=> !WINDOW_VIOL_REQ
	) else $error("clear in open window raised a violation");

	a_timeout_clear: assert property (
		WDT_TIMEOUT_RST |=> !flags[RCF_BIT_TIMEOUT]
	) else $error("time-out flag not cleared");

	a_pin_clear: assert property (
		PIN_RESET |=> !flags[RCF_BIT_PIN]
	) else $error("pin flag not cleared");

	a_instr_clear: assert property (
		RESET_INSTR |=> !flags[RCF_BIT_INSTR]
	) else $error("instruction flag not cleared");

	a_write_stores: assert property (
		(wr_flags && hw_ev == 8'h00)
		|=> (flags == ($past(REG_WDATA[7:0]) & RCF_FLAGS_MASK))
	) else $error("firmware write not stored in flags");

	a_power_flag_hold: assert property (
		!wr_flags |=> $stable(flags[RCF_BIT_POWER_ON])
	) else $error("power-on flag changed without a write");

	a_hw_no_set: assert property (
		!wr_flags |=> ((flags & ~$past(flags)) == 8'h00)
	) else $error("hardware drove a flag back to inactive");

	a_write_no_reset: assert property (
		(wr_flags && !instr_viol) |=> !WINDOW_VIOL_REQ
	) else $error("flag write started a reset request");

	a_others_kept: assert property (
		(PIN_RESET && !WDT_WINDOW_RST && !instr_viol && !WDT_TIMEOUT_RST
			&& !RESET_INSTR && !wr_flags)
		|=> (flags[5:4] == $past(flags[5:4])) && (flags[2:1] == $past(flags[2:1]))
	) else $error("pin reset disturbed another flag");

	a_irq_follows: assert property (
		(WDT_TIMEOUT_RST && st_q.mask[RCF_BIT_TIMEOUT] && !wr_mask) |=> IRQ
	) else $error("unmasked cause did not raise the interrupt");

	a_read_one_cycle: assert property (
		(REG_RD && addr_hit(REG_ADDR, RCF_OFF_IRQ_MASK))
		|=> (REG_RDATA == DATA_W'($past(st_q.mask)))
	) else $error("mask read returned wrong data");

	// A violation request only ever follows a closed-window clear
	a_viol_source: assert property (
		WINDOW_VIOL_REQ |-> $past(instr_viol)
	) else $error("violation request without a closed-window clear");

	a_window_rst_quiet: assert property (
		(WDT_WINDOW_RST && !instr_viol) |=> !WINDOW_VIOL_REQ
	) else $error("window reset input raised a violation request");

	a_open_window_flag: assert property (
		(WDT_CLEAR_INSTR && WDT_WINDOW_OPEN && !WDT_WINDOW_RST && !wr_flags)
		|=> $stable(flags[RCF_BIT_WINDOW])
	) else $error("open-window clear changed the window flag");

	a_write_window: assert property (
		(wr_flags && REG_WDATA[RCF_BIT_WINDOW] && !hw_ev[RCF_BIT_WINDOW])
		|=> flags[RCF_BIT_WINDOW]
	) else $error("window flag write of one not stored");

	a_write_timeout: assert property (
		(wr_flags && REG_WDATA[RCF_BIT_TIMEOUT] && !hw_ev[RCF_BIT_TIMEOUT])
		|=> flags[RCF_BIT_TIMEOUT]
	) else $error("time-out flag write of one not stored");

	a_write_pin: assert property (
		(wr_flags && REG_WDATA[RCF_BIT_PIN] && !hw_ev[RCF_BIT_PIN])
		|=> flags[RCF_BIT_PIN]
	) else $error("pin flag write of one not stored");

	a_write_instr: assert property (
		(wr_flags && REG_WDATA[RCF_BIT_INSTR] && !hw_ev[RCF_BIT_INSTR])
		|=> flags[RCF_BIT_INSTR]
	) else $error("instruction flag write of one not stored");

	a_power_write: assert property (
		wr_flags |=> (flags[RCF_BIT_POWER_ON] == $past(REG_WDATA[RCF_BIT_POWER_ON]))
	) else $error("power-on flag did not take the written value");

	a_timeout_kept: assert property (
		(WDT_TIMEOUT_RST && !WDT_WINDOW_RST && !instr_viol && !PIN_RESET
			&& !RESET_INSTR && !wr_flags)
		|=> (flags[5] == $past(flags[5])) && (flags[3:1] == $past(flags[3:1]))
	) else $error("time-out reset disturbed another flag");

	a_window_kept: assert property (
		(WDT_WINDOW_RST && !WDT_TIMEOUT_RST && !PIN_RESET
			&& !RESET_INSTR && !wr_flags)
		|=> (flags[4:1] == $past(flags[4:1]))
	) else $error("window reset disturbed another flag");

	a_instr_kept: assert property (
		(RESET_INSTR && !WDT_WINDOW_RST && !instr_viol && !WDT_TIMEOUT_RST
			&& !PIN_RESET && !wr_flags)
		|=> (flags[5:3] == $past(flags[5:3])) && (flags[1] == $past(flags[1]))
	) else $error("reset instruction disturbed another flag");

	// Sticky status: a cause in the same cycle as its clear still lands
	a_stat_set: assert property (
		((hw_ev & RCF_CAUSE_MASK) != 8'h00)
		|=> ((st_q.stat & $past(hw_ev & RCF_CAUSE_MASK)) == $past(hw_ev & RCF_CAUSE_MASK))
	) else $error("cause event not recorded in status");

	a_stat_clear: assert property (
		(wr_stat && hw_ev == 8'h00)
		|=> (st_q.stat == ($past(st_q.stat) & ~$past(REG_WDATA[7:0] & RCF_CAUSE_MASK)))
	) else $error("status write-one clear gave wrong bits");

	a_stat_hold: assert property (
		(!wr_stat && hw_ev == 8'h00) |=> $stable(st_q.stat)
	) else $error("status changed without event or write");

	a_mask_write: assert property (
		wr_mask |=> (st_q.mask == ($past(REG_WDATA[7:0]) & RCF_CAUSE_MASK))
	) else $error("mask write not stored");

	a_mask_hold: assert property (
		!wr_mask |=> $stable(st_q.mask)
	) else $error("mask changed without a write");

	a_irq_masked: assert property (
		(st_q.mask == 8'h00) |-> !IRQ
	) else $error("interrupt raised with every cause masked");

	// Read data fall back to zero unless a read was taken one cycle before
	a_rdata_idle: assert property (
		!REG_RD |=> (REG_RDATA == '0)
	) else $error("read data not zero outside the read cycle");

	a_read_flags: assert property (
		(REG_RD && addr_hit(REG_ADDR, RCF_OFF_FLAGS))
		|=> (REG_RDATA == DATA_W'($past(flags) & RCF_FLAGS_MASK))
	) else $error("flag read returned wrong data");

	a_read_stat: assert property (
		(REG_RD && addr_hit(REG_ADDR, RCF_OFF_IRQ_STAT))
		|=> (REG_RDATA == DATA_W'($past(st_q.stat)))
	) else $error("status read returned wrong data");

	a_read_unmapped: assert property (
		(REG_RD && !addr_hit(REG_ADDR, RCF_OFF_FLAGS)
			&& !addr_hit(REG_ADDR, RCF_OFF_IRQ_STAT) && !addr_hit(REG_ADDR, RCF_OFF_IRQ_MASK))
		|=> (REG_RDATA == '0)
	) else $error("unmapped read returned data");

endmodule

/* tb/rcf_top_test.sv */
// Self-checking testbench for the reset-cause flag block
module rcf_top_test
	import rcf_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst, wr_s, rd_s, clr_instr, win_open;
	logic [3:0] addr, cause;
	logic [7:0] wdata, d, e;
	logic [7:0] rdata, flags;
	logic viol, irq;
	int failures, total_checks;
	rcf_top u_dut (.SYS_CLK(clk), .SYS_RST(rst), .REG_ADDR(addr), .REG_WDATA(wdata),
		.REG_WR(wr_s), .REG_RD(rd_s), .REG_RDATA(rdata), .WDT_WINDOW_RST(cause[3]),
		.WDT_TIMEOUT_RST(cause[2]), .PIN_RESET(cause[1]), .RESET_INSTR(cause[0]),
		.WDT_CLEAR_INSTR(clr_instr), .WDT_WINDOW_OPEN(win_open), .WINDOW_VIOL_REQ(viol),
		.CAUSE_FLAGS(flags), .IRQ(irq));
	task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
		#1;
	endtask
	// Read data stand only in the cycle after the strobe, so sample there
	task automatic rd(input logic [3:0] a, output logic [7:0] v);
		@(posedge clk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		#1;
		v = rdata;
	endtask
	task automatic pulse(input int b);
		@(posedge clk);
		cause[b] <= 1'b1;
		@(posedge clk);
		cause[b] <= 1'b0;
		#1;
	endtask
	task automatic finish_test();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// Whole run is under a hundred cycles; this limit is generous
	initial begin
		#200000;
		failures++;
		finish_test();
	end
	initial begin
		rst = 1'b1;
		wr_s = 1'b0;
		rd_s = 1'b0;
		addr = 4'h0;
		wdata = 8'h00;
		cause = 4'h0;
		clr_instr = 1'b0;
		win_open = 1'b0;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		#1;
		chk("flags after reset", flags, 8'h3c);
		rd(RCF_OFF_FLAGS, d);
		chk("flags read", d, 8'h3c);
		chk("irq after reset", {7'h00, irq}, 8'h00);
		$display("test reset values done");
		wr(RCF_OFF_IRQ_MASK, 8'h3c);
		for (int b = 0; b < 4; b++) begin
			pulse(b);
			e = 8'h3c ^ (8'h04 << b);
			chk("cause flags", flags, e);
			chk("cause irq", {7'h00, irq}, 8'h01);
			rd(RCF_OFF_FLAGS, d);
			chk("flag held", d, e);
			rd(RCF_OFF_IRQ_STAT, d);
			chk("cause status", d, 8'h04 << b);
			wr(RCF_OFF_IRQ_STAT, 8'h04 << b);
			chk("irq cleared", {7'h00, irq}, 8'h00);
			wr(RCF_OFF_FLAGS, 8'h3c);
			chk("flags restored", flags, 8'h3c);
		end
		$display("test cause events done");
		wr(RCF_OFF_IRQ_MASK, 8'h00);
		@(posedge clk);
		win_open <= 1'b1;
		clr_instr <= 1'b1;
		@(posedge clk);
		clr_instr <= 1'b0;
		#1;
		chk("open clear viol", {7'h00, viol}, 8'h00);
		chk("open clear flags", flags, 8'h3c);
		@(posedge clk);
		win_open <= 1'b0;
		clr_instr <= 1'b1;
		@(posedge clk);
		clr_instr <= 1'b0;
		#1;
		chk("closed clear viol", {7'h00, viol}, 8'h01);
		chk("closed clear flags", flags, 8'h1c);
		chk("masked irq", {7'h00, irq}, 8'h00);
		@(posedge clk);
		#1;
		chk("viol one cycle", {7'h00, viol}, 8'h00);
		rd(RCF_OFF_IRQ_STAT, d);
		chk("viol status", d, 8'h20);
		$display("test window violation done");
		wr(RCF_OFF_FLAGS, 8'h00);
		chk("active write flags", flags, 8'h00);
		chk("active write viol", {7'h00, viol}, 8'h00);
		rd(RCF_OFF_IRQ_STAT, d);
		chk("active write status", d, 8'h20);
		wr(RCF_OFF_FLAGS, 8'hff);
		chk("all ones write", flags, 8'h3e);
		wr(4'h7, 8'hff);
		rd(4'h7, d);
		chk("unmapped read", d, 8'h00);
		rd(RCF_OFF_FLAGS, d);
		chk("unmapped write", d, 8'h3e);
		$display("test firmware writes done");
		rd(RCF_OFF_IRQ_MASK, d);
		chk("mask read", d, 8'h00);
		wr(RCF_OFF_IRQ_MASK, 8'hff);
		rd(RCF_OFF_IRQ_MASK, d);
		chk("mask bits", d, 8'h3c);
		@(posedge clk);
		#1;
		chk("read data idle", rdata, 8'h00);
		// Events collide with a status clear and a flag write; the event must win
		@(posedge clk);
		addr <= RCF_OFF_IRQ_STAT;
		wdata <= 8'h3c;
		wr_s <= 1'b1;
		cause[2] <= 1'b1;
		@(posedge clk);
		addr <= RCF_OFF_FLAGS;
		wdata <= 8'h3e;
		cause[2] <= 1'b0;
		cause[1] <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
		cause[1] <= 1'b0;
		#1;
		chk("event beats write", flags, 8'h36);
		chk("event irq", {7'h00, irq}, 8'h01);
		rd(RCF_OFF_IRQ_STAT, d);
		chk("event beats clear", d, 8'h18);
		wr(RCF_OFF_IRQ_STAT, 8'hff);
		chk("status all cleared", {7'h00, irq}, 8'h00);
		$display("test collisions done");
		@(posedge clk);
		rst <= 1'b1;
		@(posedge clk);
		rst <= 1'b0;
		#1;
		chk("flags second reset", flags, 8'h3c);
		rd(RCF_OFF_IRQ_STAT, d);
		chk("status second reset", d, 8'h00);
		rd(RCF_OFF_IRQ_MASK, d);
		chk("mask second reset", d, 8'h00);
		$display("test second reset done");
		finish_test();
	end
endmodule
